// ===== src/spi_chain_slave.sv
// spi slave with three-byte packets and daisy-chain pass-through
//
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module spi_chain_slave (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic sclk_in,
    input wire logic select_n_in,
    input wire logic mosi_in,
    output logic miso_out,
    output logic miso_oe_out,
    output logic chain_data_out,
    output logic [7:0] reg_addr_out,
    output logic [7:0] reg_wdata_out,
    output logic reg_wr_out,
    output logic reg_rd_out,
    input wire logic [7:0] reg_rdata_in,
    input wire logic reg_exists_in
);
    // ==========================================================
    // reset release and pin synchronisation
    logic rst_meta;
    logic rst_n;
    logic sclk_s;
    logic select_n_s;
    logic mosi_s;
    logic sclk_d;
    logic select_n_d;

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    pin_sync #(.RESET_VALUE(1'b0)) u_sync_sclk (
        .clock_in(clock_in), .rst_n_in(rst_n), .pin_in(sclk_in), .sync_out(sclk_s));
    pin_sync #(.RESET_VALUE(1'b1)) u_sync_select (
        .clock_in(clock_in), .rst_n_in(rst_n), .pin_in(select_n_in), .sync_out(select_n_s));
    pin_sync #(.RESET_VALUE(1'b0)) u_sync_mosi (
        .clock_in(clock_in), .rst_n_in(rst_n), .pin_in(mosi_in), .sync_out(mosi_s));

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            sclk_d <= 1'b0;
            select_n_d <= 1'b1;
        end else begin
            sclk_d <= sclk_s;
            select_n_d <= select_n_s;
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    logic sel_rise;
    logic sel_fall;
    assign sclk_rise = sclk_s & ~sclk_d;
    assign sclk_fall = ~sclk_s & sclk_d;
    assign sel_rise = select_n_s & ~select_n_d;
    assign sel_fall = ~select_n_s & select_n_d;

    // ==========================================================
    // bit counter and input shifter
    logic [3:0] bit_cnt;
    logic [7:0] shift_in;

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt <= 4'h0;
        end else if (sel_fall || (sclk_rise && select_n_s)) begin
            bit_cnt <= 4'h0;
        end else if (sclk_rise && !select_n_s && bit_cnt != spi_chain_pkg::CNT_MAX) begin
            bit_cnt <= bit_cnt + 4'h1;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            shift_in <= spi_chain_pkg::BYTE_ZERO;
        end else if (sclk_rise && !select_n_s) begin
            shift_in <= {shift_in[6:0], mosi_s};
        end
    end

    // a byte is good only with exactly eight edges; over-length bytes lose step just as short ones do
    logic byte_done;
    logic byte_bad;
    assign byte_done = sel_rise && !sclk_rise && bit_cnt == spi_chain_pkg::BYTE_BITS;
    assign byte_bad = sel_rise && !sclk_rise && bit_cnt != spi_chain_pkg::BYTE_BITS && bit_cnt != 4'h0;

    // ==========================================================
    // packet sequencer
    spi_chain_pkg::seq_state_t state;

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            state <= spi_chain_pkg::ST_CTRL;
        end else if (sclk_rise && select_n_s) begin
            state <= spi_chain_pkg::ST_CTRL;
        end else if (byte_bad) begin
            state <= spi_chain_pkg::ST_LOST;
        end else if (byte_done) begin
            unique case (state)
                spi_chain_pkg::ST_CTRL: state <= spi_chain_pkg::ST_ADDR;
                spi_chain_pkg::ST_ADDR: state <= spi_chain_pkg::ST_DATA;
                spi_chain_pkg::ST_DATA: state <= spi_chain_pkg::ST_CTRL;
                spi_chain_pkg::ST_LOST: state <= spi_chain_pkg::ST_LOST;
            endcase
        end
    end

    // ==========================================================
    // control byte and address capture
    logic broadcast_flag;
    logic ctrl_rw;
    logic [spi_chain_pkg::CID_W-1:0] chain_device_index;
    logic cid_zero;

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            broadcast_flag <= 1'b0;
            ctrl_rw <= 1'b0;
            chain_device_index <= '0;
        end else if (byte_done && state == spi_chain_pkg::ST_CTRL) begin
            broadcast_flag <= shift_in[spi_chain_pkg::BROADCAST_BIT];
            ctrl_rw <= shift_in[spi_chain_pkg::CTRL_RW_BIT];
            for (int i = 0; i < spi_chain_pkg::CID_W; i++) begin
                chain_device_index[i] <= shift_in[spi_chain_pkg::CID_W-1-i];
            end
        end
    end

    assign cid_zero = chain_device_index == '0;

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            reg_addr_out <= spi_chain_pkg::BYTE_ZERO;
        end else if (byte_done && state == spi_chain_pkg::ST_ADDR) begin
            reg_addr_out <= shift_in;
        end
    end

    // ==========================================================
    // register access strobes
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            reg_rd_out <= 1'b0;
        end else begin
            reg_rd_out <= byte_done && state == spi_chain_pkg::ST_ADDR && ctrl_rw && cid_zero;
        end
    end

    // strobe only on a clean third byte, so abandoned writes never reach a register
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            reg_wr_out <= 1'b0;
            reg_wdata_out <= spi_chain_pkg::BYTE_ZERO;
        end else begin
            reg_wr_out <= byte_done && state == spi_chain_pkg::ST_DATA && !ctrl_rw
                && (broadcast_flag || cid_zero) && reg_exists_in;
            if (byte_done && state == spi_chain_pkg::ST_DATA) begin
                reg_wdata_out <= shift_in;
            end
        end
    end

    // ==========================================================
    // read data return
    logic [7:0] rd_shift;

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            rd_shift <= spi_chain_pkg::BYTE_ZERO;
        end else if (reg_rd_out) begin
            rd_shift <= reg_exists_in ? reg_rdata_in : spi_chain_pkg::BYTE_ZERO;
        end else if (sclk_fall && !select_n_s && state == spi_chain_pkg::ST_DATA) begin
            rd_shift <= {rd_shift[6:0], 1'b0};
        end
    end

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            miso_oe_out <= 1'b0;
            miso_out <= 1'b0;
        end else begin
            miso_oe_out <= !select_n_s && state == spi_chain_pkg::ST_DATA && ctrl_rw && cid_zero;
            miso_out <= rd_shift[7];
        end
    end

    // ==========================================================
    // chain output with serial index decrement
    logic borrow;
    logic in_cid;
    assign in_cid = state == spi_chain_pkg::ST_CTRL && !select_n_s
        && bit_cnt >= spi_chain_pkg::CID_FIRST_CNT && bit_cnt <= spi_chain_pkg::CID_LAST_CNT;

    // index lsb arrives first, so the borrow ripples in wire order
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            borrow <= 1'b1;
        end else if (sel_fall) begin
            borrow <= 1'b1;
        end else if (sclk_rise && in_cid) begin
            borrow <= borrow & ~mosi_s;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            chain_data_out <= 1'b0;
        end else begin
            chain_data_out <= in_cid ? (mosi_s ^ borrow) : mosi_s;
        end
    end

    // ==========================================================
    // checks
    property p_oe_read_only;
        @(posedge clock_in) disable iff (!rst_n)
        miso_oe_out |-> $past(state == spi_chain_pkg::ST_DATA && ctrl_rw && cid_zero && !select_n_s);
    endproperty
    a_oe_read_only: assert property (p_oe_read_only) else $error("data out driven outside read data");

    property p_wr_clean_byte;
        @(posedge clock_in) disable iff (!rst_n)
        reg_wr_out |-> $past(bit_cnt) == spi_chain_pkg::BYTE_BITS && $past(state) == spi_chain_pkg::ST_DATA;
    endproperty
    a_wr_clean_byte: assert property (p_wr_clean_byte) else $error("write without clean data byte");

    property p_wr_is_write;
        @(posedge clock_in) disable iff (!rst_n)
        reg_wr_out |-> !ctrl_rw && (broadcast_flag || cid_zero);
    endproperty
    a_wr_is_write: assert property (p_wr_is_write) else $error("write strobe on read or wrong device");

    property p_rd_selected;
        @(posedge clock_in) disable iff (!rst_n)
        reg_rd_out |-> ctrl_rw && cid_zero ##1 !reg_rd_out;
    endproperty
    a_rd_selected: assert property (p_rd_selected) else $error("read strobe for unselected device");

    property p_resync;
        @(posedge clock_in) disable iff (!rst_n)
        sclk_rise && select_n_s |=> state == spi_chain_pkg::ST_CTRL && bit_cnt == 4'h0;
    endproperty
    a_resync: assert property (p_resync) else $error("clock with select high did not restart");

    property p_lose_step;
        @(posedge clock_in) disable iff (!rst_n)
        byte_bad |=> state == spi_chain_pkg::ST_LOST ##1 !reg_wr_out;
    endproperty
    a_lose_step: assert property (p_lose_step) else $error("short byte did not lose step");

    property p_count_edges;
        @(posedge clock_in) disable iff (!rst_n)
        sclk_rise && !select_n_s && bit_cnt < spi_chain_pkg::BYTE_BITS |=> bit_cnt == $past(bit_cnt) + 4'h1;
    endproperty
    a_count_edges: assert property (p_count_edges) else $error("bit count missed an edge");

    property p_missing_zero;
        @(posedge clock_in) disable iff (!rst_n)
        reg_rd_out && !reg_exists_in |=> rd_shift == spi_chain_pkg::BYTE_ZERO;
    endproperty
    a_missing_zero: assert property (p_missing_zero) else $error("missing register read not zero");

    property p_pass_through;
        @(posedge clock_in) disable iff (!rst_n)
        !in_cid |=> chain_data_out == $past(mosi_s);
    endproperty
    a_pass_through: assert property (p_pass_through) else $error("chain output altered outside index");
endmodule : spi_chain_slave
`default_nettype wire

// ===== src/spi_chain_pkg.sv
// constants shared by the three-byte spi slave front end
package spi_chain_pkg;
    // ==========================================================
    // byte framing
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] CNT_MAX = 4'h9;
    localparam logic [3:0] CID_FIRST_CNT = 4'h3;
    localparam logic [3:0] CID_LAST_CNT = 4'h7;
    // ==========================================================
    // control byte layout
    localparam int BROADCAST_BIT = 7;
    localparam int CTRL_RW_BIT = 6;
    localparam int CTRL_RSVD_BIT = 5;
    localparam int CID_W = 5;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    // ==========================================================
    // packet sequencer states, one-hot
    typedef enum logic [3:0] {
        ST_CTRL = 4'h1,
        ST_ADDR = 4'h2,
        ST_DATA = 4'h4,
        ST_LOST = 4'h8
    } seq_state_t;
endpackage : spi_chain_pkg

// ===== src/pin_sync.sv
// two-flop synchroniser for a pin from outside the clock domain
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
    parameter logic RESET_VALUE = 1'b0
) (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic pin_in,
    output logic sync_out
);
    logic meta;

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta <= RESET_VALUE;
            sync_out <= RESET_VALUE;
        end else begin
            meta <= pin_in;
            sync_out <= meta;
        end
    end
endmodule : pin_sync
`default_nettype wire

// ===== tb/spi_master_model.sv
// spi master model: frames each byte, clocks bits, samples both return lines
`timescale 1ns/1ns
`default_nettype none
module spi_master_model (
    input wire logic clock_in,
    output var logic sclk_out,
    output var logic select_n_out,
    output var logic mosi_out,
    input wire logic miso_in,
    input wire logic chain_in
);
    // ==========================================================
    // idle levels: clock stands still low outside frames, except for the resync pulse
    initial begin
        sclk_out = 1'h0;
        select_n_out = 1'h1;
        mosi_out = 1'h0;
    end

    task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx, output logic [7:0] ch);
        rx = 8'h00;
        ch = 8'h00;
        @(posedge clock_in);
        select_n_out <= 1'h0;
        for (int i = 0; i < nbits; i++) begin
            mosi_out <= tx[7 - (i % 8)];
            repeat (4) @(posedge clock_in);
            sclk_out <= 1'h1;
            // sample late in the high phase, on a falling clock edge so the outputs have settled
            repeat (3) @(posedge clock_in);
            @(negedge clock_in);
            rx = {rx[6:0], miso_in};
            ch = {ch[6:0], chain_in};
            @(posedge clock_in);
            sclk_out <= 1'h0;
        end
        repeat (4) @(posedge clock_in);
        select_n_out <= 1'h1;
        // a released data line must not keep its last level
        mosi_out <= ~mosi_out;
        repeat (8) @(posedge clock_in);
    endtask : xfer

    task automatic resync;
        @(posedge clock_in);
        sclk_out <= 1'h1;
        repeat (4) @(posedge clock_in);
        sclk_out <= 1'h0;
        repeat (8) @(posedge clock_in);
    endtask : resync
endmodule : spi_master_model
`default_nettype wire

// ===== tb/tb_top.sv
// self-checking bench for the three-byte spi slave front end
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    `define CHK(g, e) begin check_count++; if ((g) !== (e)) begin miscompares++; \
        $display("Error %0t: got %h exp %h", $time, (g), (e)); end end
    typedef struct packed {
        logic [7:0] ctl;
        logic [7:0] adr;
        logic [7:0] dat;
        logic wr;
        logic rd;
        logic [7:0] rx;
    } row_t;
    // ==========================================================
    // signals, register file stand-in, models
    int check_count = 0;
    int miscompares = 0;
    int wr_cnt = 0;
    int rd_cnt = 0;
    int oe_cnt = 0;
    logic clock_in = 1'h0;
    logic rst_n_in = 1'h0;
    logic sclk, select_n, mosi, miso_out, miso_oe_out, chain_data_out, reg_wr_out, reg_rd_out, reg_exists;
    logic [7:0] reg_addr_out, reg_wdata_out, reg_rdata;
    logic [7:0] regs [4] = '{8'h11, 8'h22, 8'h33, 8'h44};
    wire logic miso_line;
    row_t rows [9] = '{
        '{8'h00, 8'h01, 8'h5A, 1'h1, 1'h0, 8'h00},
        '{8'h98, 8'h02, 8'hC3, 1'h1, 1'h0, 8'h00},
        '{8'h10, 8'h00, 8'h77, 1'h0, 1'h0, 8'h00},
        '{8'h40, 8'h01, 8'h00, 1'h0, 1'h1, 8'h5A},
        '{8'hC0, 8'h02, 8'h00, 1'h0, 1'h1, 8'hC3},
        '{8'hC8, 8'h01, 8'h00, 1'h0, 1'h0, 8'h00},
        '{8'h40, 8'h09, 8'h00, 1'h0, 1'h1, 8'h00},
        '{8'h00, 8'h09, 8'hEE, 1'h0, 1'h0, 8'h00},
        '{8'h40, 8'h00, 8'h00, 1'h0, 1'h1, 8'h11}
    };

    always #20 clock_in = ~clock_in;
    assign miso_line = miso_oe_out ? miso_out : 1'hz;
    assign reg_exists = reg_addr_out < 8'h04;
    // missing places answer garbage, so a zero read is the slave's own doing
    assign reg_rdata = reg_exists ? regs[reg_addr_out[1:0]] : 8'hA5;

    always @(posedge clock_in) begin
        if (miso_oe_out === 1'h1) oe_cnt++;
        if (reg_rd_out === 1'h1) rd_cnt++;
        if (reg_wr_out === 1'h1) begin
            wr_cnt++;
            if (reg_exists) regs[reg_addr_out[1:0]] <= reg_wdata_out;
        end
    end

    spi_chain_slave u_spi_chain_slave (.clock_in(clock_in), .rst_n_in(rst_n_in), .sclk_in(sclk),
        .select_n_in(select_n), .mosi_in(mosi), .miso_out(miso_out), .miso_oe_out(miso_oe_out),
        .chain_data_out(chain_data_out), .reg_addr_out(reg_addr_out), .reg_wdata_out(reg_wdata_out),
        .reg_wr_out(reg_wr_out), .reg_rd_out(reg_rd_out), .reg_rdata_in(reg_rdata), .reg_exists_in(reg_exists));
    spi_master_model u_spi_master_model (.clock_in(clock_in), .sclk_out(sclk), .select_n_out(select_n),
        .mosi_out(mosi), .miso_in(miso_line), .chain_in(chain_data_out));

    // ==========================================================
    // helpers
    function automatic logic [7:0] chain_ctl(input logic [7:0] c);
        logic [4:0] idx;
        idx = {c[0], c[1], c[2], c[3], c[4]};
        idx = idx - 5'h01;
        return {c[7:5], idx[0], idx[1], idx[2], idx[3], idx[4]};
    endfunction : chain_ctl

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test

    task automatic run(input row_t r, input int n3, input logic lost);
        int w0;
        int r0;
        logic [7:0] rx, ch;
        logic [7:0] b [3];
        w0 = wr_cnt;
        r0 = rd_cnt;
        b = '{r.ctl, r.adr, r.dat};
        for (int i = 0; i < 3; i++) begin
            oe_cnt = 0;
            u_spi_master_model.xfer(b[i], i == 2 ? n3 : 8, rx, ch);
            `CHK(oe_cnt != 0, r.rd && i == 2 && n3 == 8)
            if (!lost && (i < 2 || n3 == 8)) `CHK(ch, i == 0 ? chain_ctl(r.ctl) : b[i])
        end
        `CHK(wr_cnt - w0, int'(r.wr))
        `CHK(rd_cnt - r0, int'(r.rd))
        if (!lost) `CHK(reg_addr_out, r.adr)
        if (r.rd) `CHK(rx, r.rx)
        if (r.wr) `CHK(reg_wdata_out, r.dat)
        $display("test done: ctl %h adr %h bits %0d", r.ctl, r.adr, n3);
    endtask : run

    // ==========================================================
    // main sequence
    initial begin
        logic [7:0] rx, ch;
        repeat (3) @(posedge clock_in);
        rst_n_in <= 1'h1;
        repeat (6) @(posedge clock_in);
        `CHK({chain_data_out, miso_oe_out, reg_wr_out, reg_rd_out, reg_addr_out, reg_wdata_out}, 20'h00000)
        $display("test done: reset values");
        for (int k = 0; k < 9; k++) run(rows[k], 8, 1'h0);
        run('{8'h00, 8'h03, 8'h99, 1'h0, 1'h0, 8'h00}, 5, 1'h0);
        run('{8'h00, 8'h03, 8'h99, 1'h0, 1'h0, 8'h00}, 8, 1'h1);
        u_spi_master_model.resync();
        run('{8'h00, 8'h03, 8'h66, 1'h1, 1'h0, 8'h00}, 8, 1'h0);
        run('{8'h00, 8'h03, 8'h11, 1'h0, 1'h0, 8'h00}, 9, 1'h0);
        u_spi_master_model.resync();
        run('{8'h40, 8'h03, 8'h00, 1'h0, 1'h1, 8'h66}, 8, 1'h0);
        u_spi_master_model.xfer(8'h40, 3, rx, ch);
        u_spi_master_model.resync();
        run('{8'h40, 8'h01, 8'h00, 1'h0, 1'h1, 8'h5A}, 8, 1'h0);
        u_spi_master_model.xfer(8'h00, 3, rx, ch);
        rst_n_in <= 1'h0;
        repeat (3) @(posedge clock_in);
        rst_n_in <= 1'h1;
        repeat (6) @(posedge clock_in);
        `CHK({miso_oe_out, reg_wr_out, reg_rd_out, reg_addr_out}, 11'h000)
        $display("test done: mid-run reset");
        run('{8'h00, 8'h00, 8'h3C, 1'h1, 1'h0, 8'h00}, 8, 1'h0);
        `CHK(regs[0], 8'h3C)
        end_of_test();
    end

    initial begin
        repeat (20000) @(posedge clock_in);
        miscompares++;
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
